// >>> rtl/fcx_flow_ctl.sv
// Multi-channel XON/XOFF flow controller with APB register access.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
module fcx_flow_ctl
	import fcx_pkg::*;
#(
	parameter int NCH = NUM_CH,
	parameter int DET_CYC = PAUSE_DETECT_CYC
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic ARST_N,
	// APB slave.
	input wire logic [7:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Characters from the receivers.
	input wire logic RXC_VALID,
	input wire fcx_rxc_t RXC,
	// Characters into the shared receive FIFO and its fill level.
	output logic RXF_WR,
	output fcx_rxc_t RXF,
	input wire logic [LEVEL_W-1:0] RXF_LEVEL,
	output logic RX_FIFO_CRITICAL,
	// Queued transmit data, one lane per channel.
	input wire logic [NCH-1:0] TXQ_VALID,
	input wire logic [NCH*8-1:0] TXQ_DATA,
	output logic [NCH-1:0] TXQ_POP,
	// Transmitters.
	input wire logic [NCH-1:0] TX_READY,
	output logic TX_LOAD,
	output fcx_txc_t TX
);

	////////////////////////////////////////////////////////////////////////////
	// Address and character decode helpers.

	function automatic logic is_lcr(input logic [7:0] a);
		is_lcr = (a[1:0] == 2'b00) && (a >= LCR_BASE) && (a < LCR_BASE + 8'(NCH * 4));
	endfunction : is_lcr

	function automatic logic [CH_W-1:0] lcr_ch(input logic [7:0] a);
		logic [7:0] off;
		off = a - LCR_BASE;
		lcr_ch = off[CH_W+1:2];
	endfunction : lcr_ch

	function automatic logic is_code(input fcx_rxc_t c, input logic [6:0] code);
		is_code = !c.err && (c.data[6:0] == code);
	endfunction : is_code

	////////////////////////////////////////////////////////////////////////////
	// Registers and state.

	fcx_lcr_t lcr_q [NCH];
	logic [NCH-1:0] allow_q;
	logic crit_q;
	logic [31:0] prdata_q;
	logic rxf_wr_q;
	fcx_rxc_t rxf_q;
	logic tx_load_q;
	fcx_txc_t tx_q;
	logic [CH_W-1:0] scan_q;

	logic [NCH-1:0] pause_pend, resume_pend, paused_v;
	logic [NCH-1:0] pause_ack, resume_ack, rx_tick;
	logic [NCH-1:0] inbound_auto_flow_enable_v, swp_v;
	logic wr_hit, rd_hit, hit;
	logic rx_pause, rx_resume, rx_flow;
	logic go_flow, go_data;
	logic [31:0] rd_word;

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, registered read data.

	assign hit = is_lcr(PADDR) || (PADDR == STAT_OFS);
	assign wr_hit = PSEL && PENABLE && PWRITE && PSTRB[0] && is_lcr(PADDR);
	assign rd_hit = PSEL && !PENABLE && !PWRITE;

	always_comb begin
		rd_word = '0;
		if (is_lcr(PADDR)) begin
			rd_word[LCR_INBOUND_AUTO_FLOW_ENABLE_BIT] = lcr_q[lcr_ch(PADDR)].inbound_auto_flow_enable;
			rd_word[LCR_OUTBOUND_AUTO_FLOW_ENABLE_BIT] = lcr_q[lcr_ch(PADDR)].outbound_auto_flow_enable;
			rd_word[LCR_SWP_BIT] = lcr_q[lcr_ch(PADDR)].swp;
			rd_word[LCR_SUPP_BIT] = lcr_q[lcr_ch(PADDR)].suppress;
		end else if (PADDR == STAT_OFS) begin
			rd_word[STAT_ALLOW_LSB +: NCH] = allow_q;
			rd_word[STAT_PAUSED_LSB +: NCH] = paused_v;
			rd_word[STAT_CRIT_BIT] = crit_q;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_hit) begin
			prdata_q <= rd_word;
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = 1'b1;
	// Unmapped or misaligned addresses answer with an error and read zero.
	assign PSLVERR = PSEL && PENABLE && !hit;

	// Line control registers; only byte lane 0 holds defined bits.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < NCH; i++) begin
				lcr_q[i] <= LCR_RST;
			end
		end else if (wr_hit) begin
			lcr_q[lcr_ch(PADDR)].inbound_auto_flow_enable <= PWDATA[LCR_INBOUND_AUTO_FLOW_ENABLE_BIT];
			lcr_q[lcr_ch(PADDR)].outbound_auto_flow_enable <= PWDATA[LCR_OUTBOUND_AUTO_FLOW_ENABLE_BIT];
			lcr_q[lcr_ch(PADDR)].swp <= PWDATA[LCR_SWP_BIT];
			lcr_q[lcr_ch(PADDR)].suppress <= PWDATA[LCR_SUPP_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive path.

	assign rx_pause = is_code(RXC, PAUSE_CHAR);
	assign rx_resume = is_code(RXC, RESUME_CHAR);
	assign rx_flow = rx_pause || rx_resume;

	// Flow characters are stored like data unless suppress is set for their channel.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rxf_wr_q <= 1'b0;
		end else begin
			rxf_wr_q <= RXC_VALID && !(rx_flow && lcr_q[RXC.ch].suppress);
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rxf_q <= '0;
		end else if (RXC_VALID) begin
			rxf_q <= RXC;
		end
	end

	assign RXF_WR = rxf_wr_q;
	assign RXF = rxf_q;

	// Outbound gate. Turning outbound_auto_flow_enable off reopens the gate so a stale pause
	// cannot leave a channel stuck.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			allow_q <= ALLOW_RST;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (!lcr_q[i].outbound_auto_flow_enable) begin
					allow_q[i] <= 1'b1;
				end else if (RXC_VALID && RXC.ch == CH_W'(i) && rx_pause) begin
					allow_q[i] <= 1'b0;
				end else if (RXC_VALID && RXC.ch == CH_W'(i) && rx_resume) begin
					allow_q[i] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// FIFO critical hysteresis.

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			crit_q <= 1'b0;
		end else if (RXF_LEVEL >= CRIT_SET_LEVEL) begin
			crit_q <= 1'b1;
		end else if (RXF_LEVEL <= CRIT_CLR_LEVEL) begin
			crit_q <= 1'b0;
		end
	end

	assign RX_FIFO_CRITICAL = crit_q;

	////////////////////////////////////////////////////////////////////////////
	// Per-channel inbound engines.

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		assign rx_tick[g] = RXC_VALID && RXC.ch == CH_W'(g);
		assign inbound_auto_flow_enable_v[g] = lcr_q[g].inbound_auto_flow_enable;
		assign swp_v[g] = lcr_q[g].swp;

		fcx_chan #(
			.DET_CYC(DET_CYC)
		) u_chan (
			.clk(CLK),
			.arst_n(ARST_N),
			.crit(crit_q),
			.inbound_auto_flow_enable(inbound_auto_flow_enable_v[g]),
			.swp(swp_v[g]),
			.rx_tick(rx_tick[g]),
			.pause_ack(pause_ack[g]),
			.resume_ack(resume_ack[g]),
			.pause_pend(pause_pend[g]),
			.resume_pend(resume_pend[g]),
			.paused(paused_v[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit multiplexer. One channel is visited per cycle; the scan keeps
	// a busy channel from starving the others at the cost of latency.

	logic [7:0] lane_data;

	assign lane_data = TXQ_DATA[scan_q*8 +: 8];
	assign go_flow = TX_READY[scan_q] && (pause_pend[scan_q] || resume_pend[scan_q]);
	assign go_data = TX_READY[scan_q] && !go_flow && TXQ_VALID[scan_q]
		&& allow_q[scan_q];

	always_comb begin
		pause_ack = '0;
		resume_ack = '0;
		TXQ_POP = '0;
		if (go_flow && pause_pend[scan_q]) begin
			pause_ack[scan_q] = 1'b1;
		end else if (go_flow) begin
			resume_ack[scan_q] = 1'b1;
		end
		if (go_data) begin
			TXQ_POP[scan_q] = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			scan_q <= '0;
		end else if (scan_q == CH_W'(NCH - 1)) begin
			scan_q <= '0;
		end else begin
			scan_q <= scan_q + CH_W'(1);
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tx_load_q <= 1'b0;
		end else begin
			tx_load_q <= go_flow || go_data;
		end
	end

	// Flow characters go out with bit 7 clear.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tx_q <= '0;
		end else if (go_flow && pause_pend[scan_q]) begin
			tx_q <= {scan_q, 1'b0, PAUSE_CHAR};
		end else if (go_flow) begin
			tx_q <= {scan_q, 1'b0, RESUME_CHAR};
		end else if (go_data) begin
			tx_q <= {scan_q, lane_data};
		end
	end

	assign TX_LOAD = tx_load_q;
	assign TX = tx_q;

endmodule : fcx_flow_ctl

// >>> rtl/fcx_pkg.sv
// Package of constants and carrier types for the flow-control block.
package fcx_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Geometry and timing.
	localparam int NUM_CH = 8;
	localparam int CH_W = 3;
	localparam int LEVEL_W = 9;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PAUSE_DETECT_US = 350;
	// Longest time, so the count rounds down.
	localparam int PAUSE_DETECT_CYC = (PAUSE_DETECT_US * 1000) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// Receive FIFO hysteresis levels.
	localparam logic [LEVEL_W-1:0] CRIT_SET_LEVEL = 9'h0c0;
	localparam logic [LEVEL_W-1:0] CRIT_CLR_LEVEL = 9'h07f;

	////////////////////////////////////////////////////////////////////////////
	// Flow-control codes, seven bits, parity stripped.
	localparam logic [6:0] PAUSE_CHAR = 7'h13;
	localparam logic [6:0] RESUME_CHAR = 7'h11;

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses.
	localparam logic [7:0] LCR_BASE = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h40;
	localparam int LCR_INBOUND_AUTO_FLOW_ENABLE_BIT = 1;
	localparam int LCR_OUTBOUND_AUTO_FLOW_ENABLE_BIT = 4;
	localparam int LCR_SWP_BIT = 5;
	localparam int LCR_SUPP_BIT = 6;
	localparam int STAT_ALLOW_LSB = 0;
	localparam int STAT_PAUSED_LSB = 8;
	localparam int STAT_CRIT_BIT = 16;
	localparam logic [NUM_CH-1:0] ALLOW_RST = 8'hff;

	////////////////////////////////////////////////////////////////////////////
	// Carriers.
	typedef struct packed {
		logic suppress;
		logic swp;
		logic outbound_auto_flow_enable;
		logic inbound_auto_flow_enable;
	} fcx_lcr_t;

	localparam fcx_lcr_t LCR_RST = 4'h0;

	typedef struct packed {
		logic [CH_W-1:0] ch;
		logic err;
		logic [7:0] data;
	} fcx_rxc_t;

	typedef struct packed {
		logic [CH_W-1:0] ch;
		logic [7:0] data;
	} fcx_txc_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_PAUSED = 3'b100
	} fcx_state_t;

endpackage : fcx_pkg

// >>> rtl/fcx_chan.sv
// Per-channel inbound flow engine: decides when pause and resume go out.
`timescale 1ns/10ps
module fcx_chan
	import fcx_pkg::*;
#(
	parameter int DET_CYC = PAUSE_DETECT_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Conditions.
	input wire logic crit,
	input wire logic inbound_auto_flow_enable,
	input wire logic swp,
	input wire logic rx_tick,
	// Transmitter acknowledgements.
	input wire logic pause_ack,
	input wire logic resume_ack,
	// Requests and state.
	output logic pause_pend,
	output logic resume_pend,
	output logic paused
);

	localparam int CNT_W = $clog2(DET_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DET_CYC - 1);

	fcx_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q;
	logic rx_seen_q, fifo_own_q, half_q, arm_q, swp_q, crit_q;
	logic pause_q, resume_q;
	logic fifo_src, want, issue_pause, issue_resume;

	////////////////////////////////////////////////////////////////////////////
	// A pause sent for the FIFO stays owed a resume even if inbound_auto_flow_enable drops.
	assign fifo_src = crit & ((inbound_auto_flow_enable & rx_seen_q) | fifo_own_q);
	assign want = fifo_src | swp;

	always_comb begin
		state_d = state_q;
		issue_pause = 1'b0;
		issue_resume = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (want) begin
					state_d = ST_WAIT;
				end
			end
			// A short-lived request that clears here sends nothing.
			ST_WAIT: begin
				if (!want) begin
					state_d = ST_IDLE;
				end else if (cnt_q == CNT_LAST) begin
					state_d = ST_PAUSED;
					issue_pause = 1'b1;
				end
			end
			ST_PAUSED: begin
				if (!want) begin
					state_d = ST_IDLE;
					issue_resume = 1'b1;
				end else if (swp && !swp_q) begin
					issue_pause = 1'b1;
				end else if (rx_tick && (arm_q || half_q || (crit && !crit_q && swp))) begin
					issue_pause = 1'b1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else if (state_q == ST_WAIT) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end else begin
			cnt_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Book-keeping for repeated pauses.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			swp_q <= 1'b0;
			crit_q <= 1'b0;
		end else begin
			swp_q <= swp;
			crit_q <= crit;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_seen_q <= 1'b0;
		end else if (rx_tick) begin
			rx_seen_q <= 1'b1;
		// A character seen before the FIFO turns critical still marks the channel
		// as receiving, so the first pause is not held back until the next one.
		end else if (issue_resume || (crit_q && !crit)) begin
			rx_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_own_q <= 1'b0;
		end else if (issue_resume || state_q == ST_IDLE) begin
			fifo_own_q <= 1'b0;
		end else if (state_d == ST_PAUSED && crit && inbound_auto_flow_enable) begin
			fifo_own_q <= 1'b1;
		end
	end

	// Counts received characters in pairs between pauses.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			half_q <= 1'b0;
		end else if (issue_pause || state_q != ST_PAUSED) begin
			half_q <= 1'b0;
		end else if (rx_tick) begin
			half_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arm_q <= 1'b0;
		end else if (state_q != ST_PAUSED || (rx_tick && issue_pause)) begin
			arm_q <= 1'b0;
		end else if (crit && !crit_q && swp) begin
			arm_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pending characters: a new issue wins over an acknowledge.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pause_q <= 1'b0;
		end else if (issue_pause) begin
			pause_q <= 1'b1;
		end else if (pause_ack || issue_resume) begin
			pause_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resume_q <= 1'b0;
		end else if (issue_resume) begin
			resume_q <= 1'b1;
		end else if (resume_ack || issue_pause) begin
			resume_q <= 1'b0;
		end
	end

	assign pause_pend = pause_q;
	assign resume_pend = resume_q;
	assign paused = (state_q == ST_PAUSED);

endmodule : fcx_chan

// >>> sim/fcx_term.sv
// Model of the serial transmitters and the remote terminal behind them.
`timescale 1ns/10ps
module fcx_term
	import fcx_pkg::*;
#(
	parameter int BUSY = 3
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Characters handed over.
	input wire logic tx_load,
	input wire fcx_txc_t tx,
	// Boundaries and what the terminal saw.
	output logic [NUM_CH-1:0] tx_ready,
	output logic [7:0] n_p [NUM_CH],
	output logic [7:0] n_r [NUM_CH],
	output logic [7:0] n_d [NUM_CH],
	output logic [NUM_CH-1:0] held
);
	logic [3:0] busy_q [NUM_CH];
	// A line stays busy after each load, so the block has to wait for a boundary.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) tx_ready[i] = busy_q[i] == 4'h0 && !(tx_load && tx.ch == i);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			held <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				busy_q[i] <= 4'h0;
				n_p[i] <= 8'h00;
				n_r[i] <= 8'h00;
				n_d[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) if (busy_q[i] != 4'h0) busy_q[i] <= busy_q[i] - 4'h1;
			if (tx_load) begin
				busy_q[tx.ch] <= 4'(BUSY);
				if (tx.data == 8'h13) begin
					n_p[tx.ch] <= n_p[tx.ch] + 8'h01;
					held[tx.ch] <= 1'b1;
				end else if (tx.data == 8'h11) begin
					n_r[tx.ch] <= n_r[tx.ch] + 8'h01;
					held[tx.ch] <= 1'b0;
				end else begin
					n_d[tx.ch] <= n_d[tx.ch] + 8'h01;
				end
			end
		end
	end
endmodule : fcx_term

// >>> sim/fcx_flow_ctl_checker.sv
// Port-level assertions for the flow-control block.
`timescale 1ns/10ps
module fcx_flow_ctl_checker
	import fcx_pkg::*;
#(
	parameter int NCH = NUM_CH
) (
	// Clock, reset and bus.
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [7:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PSLVERR,
	// Receive side.
	input wire logic RXC_VALID,
	input wire fcx_rxc_t RXC,
	input wire logic RXF_WR,
	input wire fcx_rxc_t RXF,
	input wire logic [LEVEL_W-1:0] RXF_LEVEL,
	input wire logic RX_FIFO_CRITICAL,
	// Transmit side.
	input wire logic [NCH-1:0] TXQ_VALID,
	input wire logic [NCH*8-1:0] TXQ_DATA,
	input wire logic [NCH-1:0] TXQ_POP,
	input wire logic [NCH-1:0] TX_READY,
	input wire logic TX_LOAD,
	input wire fcx_txc_t TX
);
	logic [7:0] pop_data;
	logic is_flow;
	always_comb begin
		pop_data = 8'h00;
		for (int i = 0; i < NCH; i++) if (TXQ_POP[i]) pop_data = TXQ_DATA[8*i +: 8];
	end
	// Parity is ignored, so both halves of the code space match.
	assign is_flow = !RXC.err && (RXC.data[6:0] == 7'h13 || RXC.data[6:0] == 7'h11);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	////////////////////////////////////////
	property p_lvl_set;
		RXF_LEVEL >= 9'h0c0 |=> RX_FIFO_CRITICAL;
	endproperty
	a_lvl_set: assert property (p_lvl_set) else $error("level flag not set");
	property p_lvl_clr;
		RXF_LEVEL <= 9'h07f |=> !RX_FIFO_CRITICAL;
	endproperty
	a_lvl_clr: assert property (p_lvl_clr) else $error("level flag not cleared");
	property p_lvl_hold;
		RXF_LEVEL > 9'h07f && RXF_LEVEL < 9'h0c0 |=> $stable(RX_FIFO_CRITICAL);
	endproperty
	a_lvl_hold: assert property (p_lvl_hold) else $error("level flag moved");
	property p_rxf_pass;
		RXC_VALID && !is_flow |=> RXF_WR && RXF == $past(RXC);
	endproperty
	a_rxf_pass: assert property (p_rxf_pass) else $error("char not stored");
	property p_pop_ok;
		TXQ_POP != '0 |-> $onehot(TXQ_POP) && (TXQ_POP & TX_READY & TXQ_VALID) == TXQ_POP;
	endproperty
	a_pop_ok: assert property (p_pop_ok) else $error("bad data pop");
	sequence s_pop;
		TXQ_POP != '0;
	endsequence
	sequence s_load;
		TX_LOAD && TX.data == $past(pop_data);
	endsequence
	property p_pop_load;
		s_pop |=> s_load;
	endproperty
	a_pop_load: assert property (p_pop_load) else $error("popped data not loaded");
	property p_flow_only;
		TX_LOAD && !$past(TXQ_POP != '0) |-> TX.data == 8'h13 || TX.data == 8'h11;
	endproperty
	a_flow_only: assert property (p_flow_only) else $error("bad own char");
	property p_slverr;
		PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR;
	endproperty
	a_slverr: assert property (p_slverr) else $error("misaligned not refused");
endmodule : fcx_flow_ctl_checker

bind fcx_flow_ctl fcx_flow_ctl_checker #(.NCH(NCH)) i_chk (
	.CLK(CLK), .ARST_N(ARST_N), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
	.PSLVERR(PSLVERR), .RXC_VALID(RXC_VALID), .RXC(RXC), .RXF_WR(RXF_WR), .RXF(RXF),
	.RXF_LEVEL(RXF_LEVEL), .RX_FIFO_CRITICAL(RX_FIFO_CRITICAL), .TXQ_VALID(TXQ_VALID),
	.TXQ_DATA(TXQ_DATA), .TXQ_POP(TXQ_POP), .TX_READY(TX_READY), .TX_LOAD(TX_LOAD), .TX(TX)
);

// >>> sim/tb_top.sv
// Self-checking bench for the flow-control block.
`timescale 1ns/10ps
module tb_top
	import fcx_pkg::*;
;
	// Short detection delay so a quick set-and-clear stays below it.
	localparam int DET = 8;
	localparam int WIN = 80;
	localparam logic [7:0] STS = 8'h40;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, rxc_valid, rxf_wr, hi, tx_load;
	logic [7:0] paddr, txq_valid, txq_pop, tx_ready, held;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [8:0] level;
	logic [63:0] txq_data;
	fcx_rxc_t rxc, rxf;
	fcx_txc_t tx;
	logic [7:0] n_p [NUM_CH], n_r [NUM_CH], n_d [NUM_CH], s_p [NUM_CH], s_r [NUM_CH], s_d [NUM_CH];
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	fcx_flow_ctl #(.DET_CYC(DET)) i_dut (
		.CLK(clk), .ARST_N(arst_n), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RXC_VALID(rxc_valid), .RXC(rxc), .RXF_WR(rxf_wr), .RXF(rxf),
		.RXF_LEVEL(level), .RX_FIFO_CRITICAL(hi), .TXQ_VALID(txq_valid), .TXQ_DATA(txq_data),
		.TXQ_POP(txq_pop), .TX_READY(tx_ready), .TX_LOAD(tx_load), .TX(tx)
	);
	fcx_term #(.BUSY(3)) i_term (.clk(clk), .arst_n(arst_n), .tx_load(tx_load), .tx(tx),
		.tx_ready(tx_ready), .n_p(n_p), .n_r(n_r), .n_d(n_d), .held(held));
	////////////////////////////////////////
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Ends once pready is high; if it never rises, only the bench timeout ends this wait.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, exp, r & m);
	endtask : rdchk
	task automatic rx(input logic [2:0] c, input logic e, input logic [7:0] d, input logic x);
		@(posedge clk);
		rxc_valid <= 1'b1;
		rxc <= '{ch: c, err: e, data: d};
		@(posedge clk);
		rxc_valid <= 1'b0;
		#1;
		chk("rxf_wr", {31'h0, x}, {31'h0, rxf_wr});
		if (x) chk("rxf", {20'h0, rxc}, {20'h0, rxf});
	endtask : rx
	task automatic snap();
		s_p = n_p;
		s_r = n_r;
		s_d = n_d;
	endtask : snap
	task automatic txw(input string nm, input int c, input int dp, input int dr, input int dd);
		repeat (WIN) @(posedge clk);
		chk({nm, " p"}, 32'(dp), {24'h0, n_p[c] - s_p[c]});
		chk({nm, " r"}, 32'(dr), {24'h0, n_r[c] - s_r[c]});
		if (dd < 0) chk({nm, " d"}, 32'h1, {31'h0, n_d[c] != s_d[c]});
		else chk({nm, " d"}, 32'(dd), {24'h0, n_d[c] - s_d[c]});
	endtask : txw
	////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		for (int i = 0; i < NUM_CH; i++) rdchk("lcr", 8'(4 * i), 32'h0000_0072, 32'h0);
		rdchk("status", STS, 32'h0001_ffff, 32'h0000_00ff);
		apb(1'b0, 8'h80, 32'h0, r, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		apb(1'b1, 8'h06, 32'h0, r, e);
		chk("misaligned err", 32'h1, {31'h0, e});
		wr(STS, 32'h0);
		rdchk("status ro", STS, 32'h0000_00ff, 32'h0000_00ff);
		wr(8'h14, 32'h0000_0020);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rdchk("sw after reset", 8'h14, 32'h0000_0020, 32'h0);
	endtask : t_reset
	task automatic t_out();
		wr(8'h00, 32'h0000_0010);
		rx(3'd0, 1'b0, 8'h93, 1'b1);
		rdchk("allow0", STS, 32'h1, 32'h0);
		txq_valid <= 8'h01;
		snap();
		wr(8'h00, 32'h0000_0030);
		txw("blocked", 0, 1, 0, 0);
		chk("held", 32'h1, {31'h0, held[0]});
		snap();
		wr(8'h00, 32'h0000_0010);
		txw("unpause", 0, 0, 1, 0);
		chk("released", 32'h0, {31'h0, held[0]});
		rx(3'd0, 1'b1, 8'h11, 1'b1);
		rdchk("allow0 err", STS, 32'h1, 32'h0);
		snap();
		rx(3'd0, 1'b0, 8'h11, 1'b1);
		txw("open", 0, 0, 0, -1);
		txq_valid <= 8'h00;
		wr(8'h00, 32'h0);
		rx(3'd0, 1'b0, 8'h13, 1'b1);
		rdchk("allow0 off", STS, 32'h1, 32'h1);
	endtask : t_out
	task automatic t_sup();
		wr(8'h04, 32'h0000_0040);
		rx(3'd1, 1'b0, 8'h13, 1'b0);
		rx(3'd1, 1'b0, 8'h91, 1'b0);
		rx(3'd1, 1'b1, 8'h13, 1'b1);
		rx(3'd1, 1'b0, 8'h53, 1'b1);
		wr(8'h04, 32'h0);
	endtask : t_sup
	task automatic t_sw();
		snap();
		wr(8'h08, 32'h0000_0020);
		txw("sw", 2, 1, 0, 0);
		rdchk("paused", STS, 32'h0000_0400, 32'h0000_0400);
		snap();
		rx(3'd2, 1'b0, 8'h41, 1'b1);
		txw("sw one", 2, 0, 0, 0);
		rx(3'd2, 1'b0, 8'h41, 1'b1);
		txw("sw two", 2, 1, 0, 0);
		snap();
		wr(8'h08, 32'h0);
		txw("sw clr", 2, 0, 1, 0);
		rdchk("resumed", STS, 32'h0000_0400, 32'h0);
		snap();
		wr(8'h08, 32'h0000_0020);
		wr(8'h08, 32'h0);
		txw("sw short", 2, 0, 0, 0);
	endtask : t_sw
	task automatic t_fill();
		wr(8'h0c, 32'h0000_0002);
		wr(8'h10, 32'h0000_0002);
		rx(3'd3, 1'b0, 8'h41, 1'b1);
		snap();
		level <= 9'h0a0;
		txw("below", 3, 0, 0, 0);
		level <= 9'h0c0;
		txw("fill", 3, 1, 0, 0);
		txw("idle ch", 4, 0, 0, 0);
		rdchk("flag", STS, 32'h0001_0000, 32'h0001_0000);
		snap();
		rx(3'd3, 1'b0, 8'h41, 1'b1);
		rx(3'd3, 1'b1, 8'h41, 1'b1);
		txw("fill two", 3, 1, 0, 0);
		snap();
		wr(8'h0c, 32'h0);
		level <= 9'h0a0;
		txw("hyst", 3, 0, 0, 0);
		level <= 9'h07f;
		txw("drain", 3, 0, 1, 0);
		rdchk("flag clr", STS, 32'h0001_0000, 32'h0);
		wr(8'h10, 32'h0);
	endtask : t_fill
	task automatic t_mix();
		wr(8'h18, 32'h0000_0002);
		rx(3'd6, 1'b0, 8'h41, 1'b1);
		snap();
		level <= 9'h0c0;
		txw("mix fill", 6, 1, 0, 0);
		wr(8'h18, 32'h0000_0022);
		txw("mix sw", 6, 2, 0, 0);
		level <= 9'h040;
		txw("mix hold", 6, 2, 0, 0);
		level <= 9'h0c0;
		rx(3'd6, 1'b0, 8'h41, 1'b1);
		txw("mix next", 6, 3, 0, 0);
		wr(8'h18, 32'h0);
		txw("mix one", 6, 3, 0, 0);
		level <= 9'h040;
		txw("mix end", 6, 3, 1, 0);
	endtask : t_mix
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		rxc_valid = 1'b0;
		rxc = '0;
		level = 9'h000;
		txq_valid = 8'h00;
		txq_data = {8{8'h41}};
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_out();
		t_sup();
		t_sw();
		t_fill();
		t_mix();
		finish_test();
	end
endmodule : tb_top
